// *** bench/host_serial_model.sv ***
// Host controller model driving the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    input wire logic sys_clk,
    output var logic ser_clk,
    output var logic ser_data,
    output var logic ser_le
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_le = 1'b0;
    end
    // Every pin level stands 4 cycles, above the 3-cycle minimum
    task automatic hold4();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            hold4();
            ser_clk = 1'b1;
            hold4();
            ser_clk = 1'b0;
        end
        // Data no longer valid, so show its inverse
        ser_data = ~ser_data;
        ser_le = 1'b1;
        hold4();
        ser_le = 1'b0;
        hold4();
    endtask
endmodule
`default_nettype wire

// *** bench/if_synth_divider_control_props.sv ***
// Concurrent checks on the IF synthesizer control ports
`timescale 1ns/1ps
`default_nettype none
module if_synth_divider_control_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ser_le,
    input wire logic ref_in,
    input wire logic presc_in,
    input wire logic pump_up,
    input wire logic pump_dn,
    input wire logic pump_high_z,
    input wire logic pump_gain_select,
    input wire logic prescaler_mode,
    input wire logic modulus_ctl,
    input wire logic synth_powerdown,
    input wire logic ref_div_pulse,
    input wire logic fb_div_pulse
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ref_gap: assert property (ref_div_pulse |=> !ref_div_pulse [*5])
        else $error("reference pulses too close");
    a_fb_gap: assert property (fb_div_pulse |=> !fb_div_pulse [*8])
        else $error("feedback pulses too close");
    a_ref_cause: assert property (!ref_in [*8] |=> !ref_div_pulse)
        else $error("reference pulse without edge");
    a_fb_cause: assert property (!presc_in [*8] |=> !fb_div_pulse)
        else $error("feedback pulse without edge");
    a_pd_quiet: assert property (synth_powerdown [*3] |->
        !pump_up && !pump_dn && !ref_div_pulse && !fb_div_pulse)
        else $error("activity while powered down");
    a_pump_clear: assert property (!(pump_up && pump_dn))
        else $error("both pumps held");
    a_hiz_quiet: assert property (pump_high_z |-> !pump_up && !pump_dn)
        else $error("pump driven in high impedance");
    a_cfg_write: assert property (!ser_le [*8] |=> $stable(pump_high_z)
        && $stable(pump_gain_select) && $stable(prescaler_mode))
        else $error("control changed without latch");
    a_pd_wake: assert property (!ser_le [*8] |=> !$fell(synth_powerdown))
        else $error("power up without latch");
    c_ref: cover property (ref_div_pulse);
    c_fb: cover property (fb_div_pulse);
    c_pd: cover property ($rose(synth_powerdown));
    c_mod: cover property ($rose(modulus_ctl));
endmodule
bind if_synth_divider_control if_synth_divider_control_props chk_u (.sys_clk, .rst,
    .ser_le, .ref_in, .presc_in, .pump_up, .pump_dn, .pump_high_z, .pump_gain_select,
    .prescaler_mode, .modulus_ctl, .synth_powerdown, .ref_div_pulse, .fb_div_pulse);
`default_nettype wire

// *** bench/tb_if_synth_divider_control.sv ***
// Self-checking bench for the IF synthesizer divider and control block
`timescale 1ns/1ps
`default_nettype none
module tb_if_synth_divider_control;
    logic sys_clk, rst, ref_in, presc_in;
    wire logic ser_clk, ser_data, ser_le;
    logic pump_up, pump_dn, pump_high_z, pump_gain_select, prescaler_mode;
    logic modulus_ctl, synth_powerdown, ref_div_pulse, fb_div_pulse;
    int num_errors = 0;
    int checked = 0;
    logic [31:0] nref, nfb, nvco;
    host_serial_model host_u (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_le(ser_le));
    if_synth_divider_control dut_u (.sys_clk(sys_clk), .rst(rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_le(ser_le), .ref_in(ref_in), .presc_in(presc_in),
        .pump_up(pump_up), .pump_dn(pump_dn), .pump_high_z(pump_high_z),
        .pump_gain_select(pump_gain_select), .prescaler_mode(prescaler_mode),
        .modulus_ctl(modulus_ctl), .synth_powerdown(synth_powerdown),
        .ref_div_pulse(ref_div_pulse), .fb_div_pulse(fb_div_pulse));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // flags are {reset, high_z, gain, polarity}; ratios kept at 3 or more
    task automatic wr3(input logic [3:0] f, input logic [14:0] r);
        host_u.send({2'h0, f, r, if_synth_pkg::ADDR_THIRD});
    endtask
    // flags are {powerdown, prescaler}; bit 21 always zero
    task automatic wr4(input logic [1:0] f, input logic [13:0] b, input logic [3:0] a);
        host_u.send({f, 1'b0, b, a, if_synth_pkg::ADDR_FOURTH});
    endtask
    // Drives n edges on both divider inputs and counts output pulses
    task automatic run(input int n);
        nref = 32'h0;
        nfb = 32'h0;
        nvco = 32'h0;
        for (int k = 0; k < n * 8 + 12; k++) begin
            ref_in = (k < n * 8) && (k % 8 < 4);
            presc_in = ref_in;
            @(posedge sys_clk);
            #1;
            nref += 32'(ref_div_pulse);
            nfb += 32'(fb_div_pulse);
            // Far-side prescaler: one period per edge, one extra input cycle while swallowing
            if (k < n * 8 && k % 8 == 7) begin
                nvco += (prescaler_mode ? 32'h10 : 32'h8) + 32'(modulus_ctl);
            end
        end
    endtask
    task automatic t_fields();
        wr3(4'h3, 15'h0003);
        wr4(2'h0, 14'h0003, 4'h1);
        chk(pump_gain_select, 1'b1);
        chk(pump_high_z, 1'b0);
        wr3(4'h5, 15'h0003);
        chk(pump_high_z, 1'b1);
        chk(pump_gain_select, 1'b0);
        host_u.send(24'hfffffd);
        chk(prescaler_mode, 1'b0);
        chk(pump_high_z, 1'b1);
        $display("t_fields done");
    endtask
    task automatic t_ref();
        wr3(4'h9, 15'h0003);
        run(12);
        chk(nref, 32'h0);
        chk(nfb, 32'h0);
        wr3(4'h1, 15'h0003);
        run(12);
        chk(nref, 32'h4);
        wr3(4'h9, 15'h0005);
        wr3(4'h1, 15'h0005);
        run(10);
        chk(nref, 32'h2);
        $display("t_ref done");
    endtask
    task automatic t_fb();
        logic ps[3] = '{1'b0, 1'b1, 1'b0};
        logic [13:0] b[3] = '{14'h0003, 14'h0003, 14'h000f};
        logic [3:0] a[3] = '{4'h1, 4'h0, 4'hf};
        int n;
        for (int i = 0; i < 3; i++) begin
            wr3(4'h9, 15'h0003);
            wr4({1'b0, ps[i]}, b[i], a[i]);
            chk(prescaler_mode, ps[i]);
            wr3(4'h1, 15'h0003);
            n = b[i] * (ps[i] ? 16 : 8) + a[i];
            run(2 * b[i]);
            chk(nfb, 32'h2);
            chk(nvco, 32'(2 * n));
        end
        $display("t_fb done");
    endtask
    task automatic t_pol();
        wr4(2'h0, 14'h0064, 4'h0);
        wr3(4'h9, 15'h0003);
        wr3(4'h1, 15'h0003);
        run(6);
        chk({pump_up, pump_dn}, 2'h2);
        wr3(4'h0, 15'h0003);
        chk({pump_up, pump_dn}, 2'h1);
        $display("t_pol done");
    endtask
    task automatic t_pd();
        wr3(4'h5, 15'h0003);
        wr4(2'h2, 14'h0064, 4'h0);
        chk(synth_powerdown, 1'b1);
        wr4(2'h0, 14'h0064, 4'h0);
        chk(synth_powerdown, 1'b0);
        wr3(4'h1, 15'h0003);
        wr4(2'h2, 14'h0064, 4'h0);
        chk(synth_powerdown, 1'b0);
        run(3);
        chk(synth_powerdown, 1'b1);
        chk({pump_up, pump_dn}, 2'h0);
        $display("t_pd done");
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        ref_in = 1'b0;
        presc_in = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_fields();
        t_ref();
        t_fb();
        t_pol();
        t_pd();
        wrap_up();
    end
endmodule
`default_nettype wire

// *** design/feedback_divider.sv ***
// Dual-modulus feedback divider: swallow counter plus binary counter
`timescale 1ns/1ps
`default_nettype none
module feedback_divider (
    input wire logic sys_clk,
    input wire logic rst,
    div_ctl_if.div dc
);
    logic [if_synth_pkg::BIN_W-1:0] bin_cnt_r;
    logic [if_synth_pkg::SWAL_W-1:0] swal_cnt_r;
    logic fb_evt_r;
    logic modulus_r;

    wire [if_synth_pkg::BIN_W-1:0] bin_inc = bin_cnt_r + 14'h0001;
    // R13: binary count sets wrap point
    wire bin_wrap = (bin_inc >= dc.bin_val);
    wire swal_busy = (swal_cnt_r < dc.swal_val);
    // R15: swallow cycles run at modulus+1, so ratio is bin * modulus + swallow
    wire swal_next_busy = bin_wrap ? (dc.swal_val != 4'h0)
                                   : ((swal_cnt_r + 4'h1) < dc.swal_val) && swal_busy;

    always_ff @(posedge sys_clk) begin
        // R08: counters held while reset bit or powerdown is active
        if (rst || dc.hold) begin
            bin_cnt_r <= '0;
            swal_cnt_r <= '0;
            fb_evt_r <= 1'b0;
            modulus_r <= 1'b0;
        end else begin
            fb_evt_r <= 1'b0;
            if (!dc.presc_evt) begin
                modulus_r <= swal_busy;
            end else if (bin_wrap) begin
                // R14: one feedback event per full binary count
                bin_cnt_r <= '0;
                swal_cnt_r <= '0;
                fb_evt_r <= 1'b1;
                modulus_r <= swal_next_busy;
            end else begin
                bin_cnt_r <= bin_inc;
                if (swal_busy) begin
                    swal_cnt_r <= swal_cnt_r + 4'h1;
                end
                modulus_r <= swal_next_busy;
            end
        end
    end

    assign dc.fb_evt = fb_evt_r;
    assign dc.modulus_ctl = modulus_r;
endmodule
`default_nettype wire

// *** design/if_synth_divider_control.sv ***
// IF synthesizer serial configuration, dividers, phase detector and pump control
//
// Summary of operation
// R01: Reference ratio is straight binary 3..32767; host never writes below 3.
// R02: Reference ratio sits in bits 17..3 of the third word.
// R03: Bit 18 of the third word picks detector sense for tuning slope.
// R04: Bit 19 of the third word picks pump current, 0 low, 1 high.
// R05: Bit 20 of the third word puts the pump output in high impedance.
// R06: High-impedance change acts at once, not at a detector event.
// R07: High-impedance bit with powerdown picks asynchronous or synchronous powerdown.
// R08: Bit 21 of the third word holds all three counters in reset.
// R09: After counter reset, feedback counters restart aligned within one prescaler cycle.
// R10: Host always writes zero into bit 21 of the fourth word.
// R11: Swallow count is bits 6..3 of the fourth word, 0..15.
// R12: Binary count is bits 20..7 of the fourth word.
// R13: Binary count lies in 3..16383; host never writes below 3.
// R14: Swallow and binary counts set the feedback divider after the prescaler.
// R15: Feedback ratio equals binary count times modulus plus swallow count.
// R16: Bit 22 of the fourth word picks modulus 8/9 or 16/17.
// R17: Bit 23 of the fourth word powers the synthesizer down.
// R18: 24-bit words, address in bits 2..0, latched on latch enable rise.
// R19: Opposite polarity swaps pump-up and pump-down outputs.
`timescale 1ns/1ps
`default_nettype none
module if_synth_divider_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_le,
    input wire logic ref_in,
    input wire logic presc_in,
    output logic pump_up,
    output logic pump_dn,
    output logic pump_high_z,
    output logic pump_gain_select,
    output logic prescaler_mode,
    output logic modulus_ctl,
    output logic synth_powerdown,
    output logic ref_div_pulse,
    output logic fb_div_pulse
);
    logic [if_synth_pkg::PIN_N-1:0] pin_s1_r;
    logic [if_synth_pkg::PIN_N-1:0] pin_s2_r;
    logic [if_synth_pkg::PIN_N-1:0] pin_s3_r;
    logic [if_synth_pkg::WORD_W-1:0] shift_r;
    logic [if_synth_pkg::WORD_W-1:0] third_config_word_r;
    logic [if_synth_pkg::WORD_W-1:0] fourth_config_word_r;
    logic [if_synth_pkg::REF_W-1:0] ref_cnt_r;
    logic ref_evt_r;
    logic powered_down_r;
    logic det_up_r;
    logic det_dn_r;
    logic pump_up_r;
    logic pump_dn_r;
    logic pump_high_z_r;
    logic gain_r;
    logic presc_mode_r;
    logic fb_pulse_r;

    div_ctl_if dc ();

    // Two-stage synchronisers, third stage only for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < if_synth_pkg::PIN_N; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_s1_r[gi] <= 1'b0;
                    pin_s2_r[gi] <= 1'b0;
                    pin_s3_r[gi] <= 1'b0;
                end else begin
                    pin_s1_r[gi] <= (gi == if_synth_pkg::PIN_SCLK) ? ser_clk :
                                    (gi == if_synth_pkg::PIN_SDATA) ? ser_data :
                                    (gi == if_synth_pkg::PIN_LE) ? ser_le :
                                    (gi == if_synth_pkg::PIN_REF) ? ref_in : presc_in;
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                end
            end
        end
    endgenerate

    wire [if_synth_pkg::PIN_N-1:0] pin_rise = pin_s2_r & ~pin_s3_r;
    wire sclk_rise = pin_rise[if_synth_pkg::PIN_SCLK];
    wire le_rise = pin_rise[if_synth_pkg::PIN_LE];
    wire ref_rise = pin_rise[if_synth_pkg::PIN_REF];
    wire presc_rise = pin_rise[if_synth_pkg::PIN_PRESC];
    wire sdata = pin_s2_r[if_synth_pkg::PIN_SDATA];

    // R18: address field of the shifted word picks the target
    wire [if_synth_pkg::ADDR_W-1:0] word_addr = shift_r[if_synth_pkg::ADDR_W-1:0];
    wire load_third = le_rise && (word_addr == if_synth_pkg::ADDR_THIRD);
    wire load_fourth = le_rise && (word_addr == if_synth_pkg::ADDR_FOURTH);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_r <= if_synth_pkg::WORD_RESET;
            third_config_word_r <= if_synth_pkg::WORD_RESET;
            fourth_config_word_r <= if_synth_pkg::WORD_RESET;
        end else begin
            // R18: most significant bit first, one bit per serial clock rise
            if (sclk_rise) begin
                shift_r <= {shift_r[if_synth_pkg::WORD_W-2:0], sdata};
            end
            if (load_third) begin
                third_config_word_r <= shift_r;
            end
            // R10: bit 21 is stored but never used
            if (load_fourth) begin
                fourth_config_word_r <= shift_r;
            end
        end
    end

    // R02: reference ratio field
    wire [if_synth_pkg::REF_W-1:0] ref_ratio =
        third_config_word_r[if_synth_pkg::REF_LSB +: if_synth_pkg::REF_W];
    // R03: detector sense
    wire polarity_pos = third_config_word_r[if_synth_pkg::POL_BIT];
    // R04: pump current level
    wire gain_high = third_config_word_r[if_synth_pkg::GAIN_BIT];
    // R05: pump high impedance
    wire hiz_bit = third_config_word_r[if_synth_pkg::HIZ_BIT];
    // R08: counter reset
    wire counter_rst = third_config_word_r[if_synth_pkg::CRST_BIT];
    // R17: synthesizer powerdown
    wire pd_bit = fourth_config_word_r[if_synth_pkg::PD_BIT];
    // R16: prescaler modulus select
    wire presc_sel = fourth_config_word_r[if_synth_pkg::PSEL_BIT];

    // R07: with high impedance set powerdown is immediate, else at next detector event
    wire pd_nxt = !pd_bit ? 1'b0 :
                  hiz_bit ? 1'b1 :
                  (powered_down_r || ref_evt_r || dc.fb_evt);
    wire hold = counter_rst || powered_down_r;

    // R01: reference counter wraps after ratio input edges
    wire [if_synth_pkg::REF_W-1:0] ref_inc = ref_cnt_r + 15'h0001;
    wire ref_wrap = (ref_inc >= ref_ratio);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powered_down_r <= 1'b0;
            ref_cnt_r <= '0;
            ref_evt_r <= 1'b0;
        end else begin
            powered_down_r <= pd_nxt;
            ref_evt_r <= 1'b0;
            // R09: all counters restart together when hold drops
            if (hold) begin
                ref_cnt_r <= '0;
            end else if (ref_rise) begin
                ref_cnt_r <= ref_wrap ? '0 : ref_inc;
                ref_evt_r <= ref_wrap;
            end
        end
    end

    // R14: feedback divider configured from the fourth word
    assign dc.presc_evt = presc_rise;
    assign dc.hold = hold;
    // R11: swallow count field
    assign dc.swal_val = fourth_config_word_r[if_synth_pkg::SWAL_LSB +: if_synth_pkg::SWAL_W];
    // R12: binary count field
    assign dc.bin_val = fourth_config_word_r[if_synth_pkg::BIN_LSB +: if_synth_pkg::BIN_W];

    feedback_divider u_fb (
        .sys_clk(sys_clk),
        .rst(rst),
        .dc(dc.div)
    );

    // Phase/frequency detector: both flags set means both clear
    wire up_set = det_up_r || ref_evt_r;
    wire dn_set = det_dn_r || dc.fb_evt;
    wire both_set = up_set && dn_set;
    // R19: negative slope swaps the pump directions
    wire up_drive = polarity_pos ? det_up_r : det_dn_r;
    wire dn_drive = polarity_pos ? det_dn_r : det_up_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            det_up_r <= 1'b0;
            det_dn_r <= 1'b0;
            pump_up_r <= 1'b0;
            pump_dn_r <= 1'b0;
            pump_high_z_r <= 1'b0;
            gain_r <= 1'b0;
            presc_mode_r <= 1'b0;
            fb_pulse_r <= 1'b0;
        end else begin
            det_up_r <= !hold && up_set && !both_set;
            det_dn_r <= !hold && dn_set && !both_set;
            // R05: high impedance forces both pump drives off
            // R06: follows the bit on the next clock, no event wait
            pump_high_z_r <= hiz_bit;
            pump_up_r <= !hiz_bit && !hold && up_drive;
            pump_dn_r <= !hiz_bit && !hold && dn_drive;
            gain_r <= gain_high;
            presc_mode_r <= presc_sel;
            fb_pulse_r <= dc.fb_evt;
        end
    end

    assign pump_up = pump_up_r;
    assign pump_dn = pump_dn_r;
    assign pump_high_z = pump_high_z_r;
    assign pump_gain_select = gain_r;
    assign prescaler_mode = presc_mode_r;
    assign modulus_ctl = dc.modulus_ctl;
    assign synth_powerdown = powered_down_r;
    assign ref_div_pulse = ref_evt_r;
    assign fb_div_pulse = fb_pulse_r;
endmodule
`default_nettype wire

// *** shared/div_ctl_if.sv ***
// Carrier between the control top and the feedback divider
`timescale 1ns/1ps
`default_nettype none
interface div_ctl_if;
    logic presc_evt;
    logic hold;
    logic [if_synth_pkg::SWAL_W-1:0] swal_val;
    logic [if_synth_pkg::BIN_W-1:0] bin_val;
    logic fb_evt;
    logic modulus_ctl;
    modport ctl (output presc_evt, hold, swal_val, bin_val, input fb_evt, modulus_ctl);
    modport div (input presc_evt, hold, swal_val, bin_val, output fb_evt, modulus_ctl);
endinterface
`default_nettype wire

// *** shared/if_synth_pkg.sv ***
// Constants for the IF synthesizer divider and control block
package if_synth_pkg;
    localparam int WORD_W = 24;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_THIRD = 3'h3;
    localparam logic [2:0] ADDR_FOURTH = 3'h4;
    localparam logic [23:0] WORD_RESET = 24'h000000;
    // Third configuration word fields
    localparam int REF_LSB = 3;
    localparam int REF_W = 15;
    localparam int POL_BIT = 18;
    localparam int GAIN_BIT = 19;
    localparam int HIZ_BIT = 20;
    localparam int CRST_BIT = 21;
    // Fourth configuration word fields
    localparam int SWAL_LSB = 3;
    localparam int SWAL_W = 4;
    localparam int BIN_LSB = 7;
    localparam int BIN_W = 14;
    localparam int PSEL_BIT = 22;
    localparam int PD_BIT = 23;
    // Pin synchroniser slots
    localparam int PIN_N = 5;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDATA = 1;
    localparam int PIN_LE = 2;
    localparam int PIN_REF = 3;
    localparam int PIN_PRESC = 4;
endpackage
